// ===== gpsc_pkg.sv
// Register map, field positions, reset values and types for the PHY status/control bank
package gpsc_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] GPSC_ADDR_GSTAT = 8'h14;
  localparam logic [7:0] GPSC_ADDR_XABIL = 8'h1E;
  localparam logic [7:0] GPSC_ADDR_CODCTL = 8'h20;
  localparam logic [7:0] GPSC_ADDR_IRQ_STAT = 8'h40;
  localparam logic [7:0] GPSC_ADDR_IRQ_MASK = 8'h44;
  // Status word fields
  localparam int GPSC_ST_MSFAULT = 15;
  localparam int GPSC_ST_MASTER = 14;
  localparam int GPSC_ST_LRX_OK = 13;
  localparam int GPSC_ST_RRX_OK = 12;
  localparam int GPSC_ST_LP_FD = 11;
  localparam int GPSC_ST_LP_HD = 10;
  localparam logic [15:0] GPSC_GSTAT_RESET = 16'h0000;
  // Extended ability word: no 1000X, 1000T full and half
  localparam logic [15:0] GPSC_XABIL_VALUE = 16'h3000;
  // Coding control fields
  localparam int GPSC_CC_RSV15 = 15;
  localparam int GPSC_CC_NO_XOVER = 14;
  localparam int GPSC_CC_TX_DIS = 13;
  localparam int GPSC_CC_BYP_4B5B = 10;
  localparam int GPSC_CC_BYP_SCR = 9;
  localparam int GPSC_CC_BYP_NRZI = 8;
  localparam int GPSC_CC_BYP_ALIGN = 7;
  localparam int GPSC_CC_SCR_RST = 6;
  localparam int GPSC_CC_RSV2 = 2;
  localparam int GPSC_CC_RSV1 = 1;
  localparam int GPSC_CC_FIFO_HI = 0;
  // Stored (read/write) bits of coding control
  localparam logic [15:0] GPSC_CODCTL_WMASK = 16'hE787;
  localparam logic [15:0] GPSC_CODCTL_RESET = 16'h0000;
  // Interrupt status bits
  localparam int GPSC_IRQ_W = 4;
  localparam int GPSC_IRQ_MSFAULT = 0;
  localparam int GPSC_IRQ_IDLE_ERR = 1;
  localparam int GPSC_IRQ_LRX_CHG = 2;
  localparam int GPSC_IRQ_CNT_SAT = 3;
  localparam logic [GPSC_IRQ_W-1:0] GPSC_IRQ_RESET = 4'h0;
  localparam logic [7:0] GPSC_IDLE_MAX = 8'hFF;
  localparam logic [7:0] GPSC_IDLE_ZERO = 8'h00;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } gpsc_req_s;

  // Link-side status reported by the PHY core
  typedef struct packed {
    logic ms_fault;
    logic is_master;
    logic local_rx_ok;
    logic remote_rx_ok;
    logic lp_1000_fd;
    logic lp_1000_hd;
    logic idle_err;
  } gpsc_link_s;

  // Controls driven into the 100BASE-TX/1000BASE-T datapath
  typedef struct packed {
    logic xover_auto;
    logic tx_disable;
    logic bypass_4b5b;
    logic bypass_scrambler;
    logic bypass_nrzi;
    logic bypass_align;
    logic scrambler_reset;
    logic fifo_high_latency;
  } gpsc_ctl_s;

  // Which register a strobe addresses
  typedef enum logic [5:0] {
    GPSC_SEL_NONE = 6'b000001,
    GPSC_SEL_GSTAT = 6'b000010,
    GPSC_SEL_XABIL = 6'b000100,
    GPSC_SEL_CODCTL = 6'b001000,
    GPSC_SEL_ISTAT = 6'b010000,
    GPSC_SEL_IMASK = 6'b100000
  } gpsc_sel_e;

  // Address decode shared by read and write paths
  function automatic gpsc_sel_e gpsc_decode(input logic [7:0] addr);
    gpsc_sel_e sel;
    sel = GPSC_SEL_NONE;
    if (addr == GPSC_ADDR_GSTAT)
      sel = GPSC_SEL_GSTAT;
    else if (addr == GPSC_ADDR_XABIL)
      sel = GPSC_SEL_XABIL;
    else if (addr == GPSC_ADDR_CODCTL)
      sel = GPSC_SEL_CODCTL;
    else if (addr == GPSC_ADDR_IRQ_STAT)
      sel = GPSC_SEL_ISTAT;
    else if (addr == GPSC_ADDR_IRQ_MASK)
      sel = GPSC_SEL_IMASK;
    return sel;
  endfunction
endpackage

// ===== gpsc_idle_counter.sv
// Saturating idle error counter, cleared by a read of the status word
module gpsc_idle_counter
  import gpsc_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Events
  input wire logic err_i,
  input wire logic clear_i,
  // Count
  output logic [7:0] count_o,
  output logic sat_o
);
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      count_o <= GPSC_IDLE_ZERO;
    else if (clear_i)
      // An error in the read cycle starts the next count
      count_o <= err_i ? 8'h01 : GPSC_IDLE_ZERO; // [RULE6]
    else if (err_i && count_o != GPSC_IDLE_MAX)
      count_o <= count_o + 8'h01; // [RULE6]
  end

  assign sat_o = err_i && !clear_i && (count_o == GPSC_IDLE_MAX);
endmodule // gpsc_idle_counter

// ===== gpsc_irq.sv
// Sticky interrupt status with write-one-to-clear and a mask
module gpsc_irq
  import gpsc_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Events and software access
  input wire logic [GPSC_IRQ_W-1:0] event_i,
  input wire logic clr_wr_i,
  input wire logic mask_wr_i,
  input wire logic [GPSC_IRQ_W-1:0] wdata_i,
  // State
  output logic [GPSC_IRQ_W-1:0] status_o,
  output logic [GPSC_IRQ_W-1:0] mask_o,
  output logic irq_o
);
  // Set wins over a clear in the same cycle
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      status_o <= GPSC_IRQ_RESET;
    else
      status_o <= (status_o & ~(clr_wr_i ? wdata_i : GPSC_IRQ_RESET)) | event_i;
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      mask_o <= GPSC_IRQ_RESET;
    else if (mask_wr_i)
      mask_o <= wdata_i;
  end

  assign irq_o = |(status_o & mask_o);
endmodule // gpsc_irq

// ===== gpsc_regs.sv
// Gigabit PHY status and coding control register bank
// Functional notes
// [RULE1] Latch master/slave fault until status read
// [RULE2] Bit 14 shows master (1) or slave
// [RULE3] Bit 13 shows local receiver OK
// [RULE4] Bit 12 shows remote receiver OK
// [RULE5] Bits 11/10 show partner full/half ability
// [RULE6] Bits 7:0 count idle errors, read clears
// [RULE7] Software trusts 14/11/10 after autoneg complete
// [RULE8] Ability word: no 1000X, 1000T full/half
// [RULE9] Control bit 14 disables automatic crossover
// [RULE10] Control bit 13 disables transmitter outputs
// [RULE11] Control bit 10 bypasses 4B/5B coder
// [RULE12] Control bit 9 disables scrambler, descrambler
// [RULE13] Control bit 8 bypasses NRZI/MLT3 coding
// [RULE14] Control bit 7 stops 5B symbol alignment
// [RULE15] Control bit 6 resets scrambler, self-clears
// [RULE16] Control bit 0 selects FIFO high latency
// [RULE17] Software writes reserved bits 15,2,1 as 0
// [RULE18] Read clears fault unless still present
//
// The address-and-strobe port was left to the implementer.
module gpsc_regs
  import gpsc_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // PHY core status
  input wire gpsc_link_s link_i,
  input wire logic an_complete_i,
  // Datapath controls
  output gpsc_ctl_s ctl_o,
  // Interrupt
  output logic irq_o
);
  gpsc_req_s req;
  gpsc_sel_e wsel;
  gpsc_sel_e rsel;
  logic ms_fault_latch;
  logic [15:0] codctl;
  logic scr_rst_pulse;
  logic [7:0] idle_count;
  logic idle_sat;
  logic gstat_read;
  logic lrx_prev;
  logic [GPSC_IRQ_W-1:0] irq_event;
  logic [GPSC_IRQ_W-1:0] irq_status;
  logic [GPSC_IRQ_W-1:0] irq_mask;
  logic [15:0] gstat_word;
  logic [15:0] next_rdata;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  assign wsel = req.wr ? gpsc_decode(req.addr) : GPSC_SEL_NONE;
  assign rsel = req.rd ? gpsc_decode(req.addr) : GPSC_SEL_NONE;
  assign gstat_read = (rsel == GPSC_SEL_GSTAT);

  // Fault latch: a new fault wins over a read clear
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      ms_fault_latch <= 1'b0;
    else if (link_i.ms_fault)
      ms_fault_latch <= 1'b1; // [RULE1] [RULE18]
    else if (gstat_read)
      ms_fault_latch <= 1'b0; // [RULE18]
  end

  gpsc_idle_counter u_idle
  (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .err_i(link_i.idle_err),
    .clear_i(gstat_read),
    .count_o(idle_count),
    .sat_o(idle_sat)
  );

  // Status word assembled live; reserved bits 9:8 read as zero
  always_comb
  begin
    gstat_word = GPSC_GSTAT_RESET;
    gstat_word[GPSC_ST_MSFAULT] = ms_fault_latch; // [RULE1]
    gstat_word[GPSC_ST_MASTER] = link_i.is_master; // [RULE2] [RULE7]
    gstat_word[GPSC_ST_LRX_OK] = link_i.local_rx_ok; // [RULE3]
    gstat_word[GPSC_ST_RRX_OK] = link_i.remote_rx_ok; // [RULE4]
    gstat_word[GPSC_ST_LP_FD] = link_i.lp_1000_fd; // [RULE5]
    gstat_word[GPSC_ST_LP_HD] = link_i.lp_1000_hd; // [RULE5]
    gstat_word[7:0] = idle_count; // [RULE6]
  end

  // Coding control: stored bits only; bit 6 never stored
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      codctl <= GPSC_CODCTL_RESET;
    else if (wsel == GPSC_SEL_CODCTL)
      codctl <= req.wdata & GPSC_CODCTL_WMASK; // [RULE17]
  end

  // Scrambler reset: one-cycle pulse, reads back as zero
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      scr_rst_pulse <= 1'b0;
    else
      scr_rst_pulse <= (wsel == GPSC_SEL_CODCTL) && req.wdata[GPSC_CC_SCR_RST]; // [RULE15]
  end

  // Datapath controls from flip-flops
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      ctl_o <= '{xover_auto: 1'b1, default: 1'b0};
    else
    begin
      ctl_o.xover_auto <= !codctl[GPSC_CC_NO_XOVER]; // [RULE9]
      ctl_o.tx_disable <= codctl[GPSC_CC_TX_DIS]; // [RULE10]
      ctl_o.bypass_4b5b <= codctl[GPSC_CC_BYP_4B5B]; // [RULE11]
      ctl_o.bypass_scrambler <= codctl[GPSC_CC_BYP_SCR]; // [RULE12]
      ctl_o.bypass_nrzi <= codctl[GPSC_CC_BYP_NRZI]; // [RULE13]
      ctl_o.bypass_align <= codctl[GPSC_CC_BYP_ALIGN]; // [RULE14]
      ctl_o.scrambler_reset <= scr_rst_pulse; // [RULE15]
      ctl_o.fifo_high_latency <= codctl[GPSC_CC_FIFO_HI]; // [RULE16]
    end
  end

  // Local receiver edge tracking for change interrupt
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      lrx_prev <= 1'b0;
    else
      lrx_prev <= link_i.local_rx_ok;
  end

  always_comb
  begin
    irq_event = GPSC_IRQ_RESET;
    irq_event[GPSC_IRQ_MSFAULT] = link_i.ms_fault && !ms_fault_latch;
    irq_event[GPSC_IRQ_IDLE_ERR] = link_i.idle_err;
    irq_event[GPSC_IRQ_LRX_CHG] = link_i.local_rx_ok ^ lrx_prev;
    irq_event[GPSC_IRQ_CNT_SAT] = idle_sat;
  end

  gpsc_irq u_irq
  (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .event_i(irq_event),
    .clr_wr_i(wsel == GPSC_SEL_ISTAT),
    .mask_wr_i(wsel == GPSC_SEL_IMASK),
    .wdata_i(req.wdata[GPSC_IRQ_W-1:0]),
    .status_o(irq_status),
    .mask_o(irq_mask),
    .irq_o(irq_o)
  );

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    next_rdata = 16'h0000;
    case (rsel)
      GPSC_SEL_GSTAT: next_rdata = gstat_word;
      GPSC_SEL_XABIL: next_rdata = GPSC_XABIL_VALUE; // [RULE8]
      GPSC_SEL_CODCTL: next_rdata = codctl;
      GPSC_SEL_ISTAT: next_rdata = {12'h000, irq_status};
      GPSC_SEL_IMASK: next_rdata = {12'h000, irq_mask};
      default: next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rdata_o <= 16'h0000;
    else
      rdata_o <= next_rdata;
  end

  // Autoneg complete is for software only
  logic unused_an;
  assign unused_an = an_complete_i; // [RULE7]
endmodule // gpsc_regs

// ===== gpsc_regs_props.sv
// Concurrent checks on the register bank ports
module gpsc_regs_props
  import gpsc_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  // Link, controls, interrupt
  input wire gpsc_link_s link_i,
  input wire logic an_complete_i,
  input wire gpsc_ctl_s ctl_o,
  input wire logic irq_o
);
  logic rg;
  logic rx;
  logic wc;
  assign rg = rd_i && addr_i == GPSC_ADDR_GSTAT;
  assign rx = rd_i && addr_i == GPSC_ADDR_XABIL;
  assign wc = wr_i && addr_i == GPSC_ADDR_CODCTL;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  chk_fault_latch: assert property (link_i.ms_fault ##1 rg |=> rdata_o[15])
    else $error("fault not latched");
  chk_fault_hold: assert property (rg && link_i.ms_fault ##1 rg |=> rdata_o[15])
    else $error("fault lost while present");
  chk_fault_clear: assert property
    (rg && !link_i.ms_fault ##1 rg && !link_i.ms_fault |=> !rdata_o[15])
    else $error("fault not cleared by read");
  chk_live_bits: assert property
    (rg |=> rdata_o[14:8] == {$past(link_i[5:1]), 2'b00})
    else $error("live status bits wrong");
  chk_count_clear: assert property
    (rg && !link_i.idle_err ##1 rg |=> rdata_o[7:0] == 8'h00)
    else $error("count not cleared by read");
  chk_ability_word: assert property (rx |=> rdata_o == GPSC_XABIL_VALUE)
    else $error("ability word wrong");
  chk_xover_ctl: assert property
    (wc |-> ##2 ctl_o.xover_auto == !$past(wdata_i[14], 2))
    else $error("crossover control wrong");
  chk_txdis_ctl: assert property
    (wc |-> ##2 ctl_o.tx_disable == $past(wdata_i[13], 2))
    else $error("transmit disable wrong");
  chk_bypass_ctl: assert property
    (wc |-> ##2 ctl_o[5:2] == $past(wdata_i[10:7], 2))
    else $error("bypass controls wrong");
  chk_scr_pulse: assert property
    (ctl_o.scrambler_reset |-> $past(wc && wdata_i[6], 2))
    else $error("scrambler reset without write");
  chk_fifo_ctl: assert property
    (wc |-> ##2 ctl_o.fifo_high_latency == $past(wdata_i[0], 2))
    else $error("fifo latency wrong");
  cover property (rg && link_i.ms_fault);
  cover property (wc && wdata_i[6]);
  cover property (rg ##1 rdata_o[7:0] == 8'hFF);
  cover property (irq_o);
endmodule // gpsc_regs_props

bind gpsc_regs gpsc_regs_props u_props (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link_i(link_i),
  .an_complete_i(an_complete_i), .ctl_o(ctl_o), .irq_o(irq_o));

// ===== gpsc_link_model.sv
// Link partner model: status levels and idle error bursts
module gpsc_link_model
  import gpsc_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Commands
  input wire gpsc_link_s cfg_i,
  input wire logic burst_i,
  input wire logic [8:0] n_i,
  input wire logic slow_i,
  // Link side
  output gpsc_link_s link_o,
  output logic done_o
);
  logic [8:0] left;
  logic ph;
  logic fire;
  assign fire = left != 9'h000 && (!slow_i || ph);
  assign done_o = left == 9'h000 && !link_o.idle_err;
  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
    begin
      left <= 9'h000;
      ph <= 1'b0;
      link_o <= '0;
    end
    else
    begin
      ph <= ~ph;
      link_o <= {cfg_i[6:1], fire};
      if (burst_i)
        left <= n_i;
      else if (fire)
        left <= left - 9'h001;
    end
endmodule // gpsc_link_model

// ===== gpsc_regs_tb.sv
// Self-checking bench for the PHY status and coding control bank
module gpsc_regs_tb import gpsc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i;
  logic nrst_i;
  logic [7:0] addr_i;
  logic [15:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [15:0] rdata_o;
  logic an_complete_i;
  gpsc_link_s cfg;
  gpsc_link_s link;
  gpsc_ctl_s ctl_o;
  logic irq_o;
  logic burst;
  logic [8:0] nerr;
  logic slow;
  logic done;
  int miscompares;
  int cmp_count;
  int n;
  logic [15:0] d;
  logic [15:0] e;
  logic [15:0] w;
  logic [7:0] ra [5] = '{GPSC_ADDR_GSTAT, GPSC_ADDR_XABIL, GPSC_ADDR_CODCTL, GPSC_ADDR_IRQ_MASK, 8'h22};
  logic [15:0] rv [5] = '{GPSC_GSTAT_RESET, GPSC_XABIL_VALUE, GPSC_CODCTL_RESET, 16'h0000, 16'h0000};
  gpsc_regs dut (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link_i(link), .an_complete_i(an_complete_i),
    .ctl_o(ctl_o), .irq_o(irq_o));
  gpsc_link_model lp (.clock_i(clock_i), .nrst_i(nrst_i), .cfg_i(cfg), .burst_i(burst),
    .n_i(nerr), .slow_i(slow), .link_o(link), .done_o(done));
  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  // Two reads back to back, no gap between strobes
  task automatic rd2(input logic [7:0] a, output logic [15:0] v1, output logic [15:0] v2);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    #1 v1 = rdata_o;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 v2 = rdata_o;
  endtask
  task automatic errs(input int k, input logic s);
    @(posedge clock_i);
    burst <= 1'b1;
    nerr <= k[8:0];
    slow <= s;
    @(posedge clock_i);
    burst <= 1'b0;
    @(posedge clock_i);
    for (int i = 0; i < 700 && !done; i++) @(posedge clock_i);
    repeat (2) @(posedge clock_i);
  endtask
  task automatic fault(input logic f);
    @(posedge clock_i);
    cfg.ms_fault <= f;
    repeat (3) @(posedge clock_i);
  endtask
  function automatic logic [15:0] egs(input gpsc_link_s c, input logic f, input int k);
    egs = {f, c[5:1], 2'b00, (k > 255) ? 8'hFF : k[7:0]};
  endfunction
  function automatic logic [7:0] ectl(input logic [15:0] v);
    ectl = {~v[14], v[13], v[10:6], v[0]};
  endfunction
  task automatic stop_test();
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    {nrst_i, wr_i, rd_i, an_complete_i, burst, slow} = '0;
    {addr_i, wdata_i, nerr} = '0;
    cfg = '0;
    miscompares = 0;
    cmp_count = 0;
    void'($urandom(32'h32e93e69));
    repeat (8) @(posedge clock_i);
    nrst_i <= 1'b1;
    check({7'h00, irq_o, ctl_o}, 16'h0080);
    foreach (ra[i])
    begin
      rd(ra[i], d);
      check(d, rv[i]);
    end
    for (int i = 0; i < 10; i++)
    begin
      w = (i == 0) ? 16'h67C1 : 16'($urandom) & 16'h7FF9;
      wr(GPSC_ADDR_CODCTL, w);
      @(posedge clock_i);
      #1 check({14'h0000, ctl_o[7:6]}, {14'h0000, ~w[14], w[13]});
      check({12'h000, ctl_o[5:2]}, {12'h000, w[10:7]});
      check({8'h00, ctl_o}, {8'h00, ectl(w)});
      rd(GPSC_ADDR_CODCTL, d);
      check(d, w & GPSC_CODCTL_WMASK);
      check({15'h0000, ctl_o.scrambler_reset}, 16'h0000);
    end
    @(posedge clock_i);
    an_complete_i <= 1'b1;
    repeat (8)
    begin
      cfg <= {1'b0, 5'($urandom), 1'b0};
      repeat (3) @(posedge clock_i);
      rd(GPSC_ADDR_GSTAT, d);
      check(d, egs(cfg, 1'b0, 0));
    end
    fault(1'b1);
    fault(1'b0);
    rd2(GPSC_ADDR_GSTAT, e, d);
    check(e, egs(cfg, 1'b1, 0));
    check(d, egs(cfg, 1'b0, 0));
    fault(1'b1);
    rd2(GPSC_ADDR_GSTAT, e, d);
    check(e, egs(cfg, 1'b1, 0));
    check(d, egs(cfg, 1'b1, 0));
    fault(1'b0);
    rd(GPSC_ADDR_GSTAT, d);
    check(d, egs(cfg, 1'b1, 0));
    wr(GPSC_ADDR_IRQ_STAT, 16'h000F);
    wr(GPSC_ADDR_IRQ_MASK, 16'h0002);
    for (int i = 0; i < 6; i++)
    begin
      n = (i == 0) ? 300 : (i == 1) ? 1 : 1 + $urandom % 40;
      errs(n, i[0]);
      check({15'h0000, irq_o}, 16'h0001);
      rd2(GPSC_ADDR_GSTAT, e, d);
      check(e, egs(cfg, 1'b0, n));
      check(d, egs(cfg, 1'b0, 0));
      wr(GPSC_ADDR_IRQ_STAT, 16'h0002);
      @(posedge clock_i);
      #1 check({15'h0000, irq_o}, 16'h0000);
    end
    wr(GPSC_ADDR_IRQ_MASK, 16'h0000);
    errs(5, 1'b0);
    check({15'h0000, irq_o}, 16'h0000);
    rd(GPSC_ADDR_IRQ_STAT, d);
    check(d & 16'h000B, 16'h000A);
    stop_test();
  end
  initial
  begin
    #400us;
    miscompares++;
    stop_test();
  end
endmodule // gpsc_regs_tb
